/* design/nvcfg_pkg.sv */
// What this block does
// - After power-on or bus reset, scan configuration memory and load all settings.
// - Offer transmit, receive and combined activity indicator pin functions.
// - Activity pin drives low during transfers, otherwise high impedance.
// - Each activity indicator is stretched by a retriggerable one-shot.
// - Optional suspend pull-down pulls UART lines low in suspend; default off.
// - Remote wake-up, default on: ring-indicate held low for 20 ms wakes host.
// - Sleep indicator pin outputs 0 while suspended, 1 otherwise.
// - Default pins: 0 transmit enable, 1 rx activity, 2 tx activity, 3 sleep.
// - Per-line polarity invert bits for eight UART signals, all default off.
// - Charge detection output stays inactive once enumerated by a standard host.
// - Default descriptor reports USB version 0200; device is full speed only.
// - Default descriptor reports bus powered with 90 mA maximum current.
// - Serial number enabled by default; unique value read from memory.
// - Transmit enable asserts one bit before start, drops with stop bit.
package nvcfg_pkg;
  localparam int unsigned CFG_WORDS      = 8;
  localparam int unsigned CFG_AW         = 3;
  localparam logic [2:0]  ADDR_USBVER    = 3'h0;
  localparam logic [2:0]  ADDR_POWER     = 3'h1;
  localparam logic [2:0]  ADDR_OPTIONS   = 3'h2;
  localparam logic [2:0]  ADDR_PINS      = 3'h3;
  localparam logic [2:0]  ADDR_INVERT    = 3'h4;
  localparam logic [2:0]  ADDR_SERIAL    = 3'h5;
  localparam logic [15:0] DEF_USBVER     = 16'h0200;
  // The current field counts 2 mA units, so the default 90 mA reads as 45.
  localparam logic [15:0] DEF_POWER      = 16'h002D;
  localparam logic [15:0] DEF_OPTIONS    = 16'h0005;
  localparam logic [15:0] DEF_PINS       = 16'h5210;
  localparam logic [15:0] DEF_INVERT     = 16'h0000;
  localparam logic [15:0] DEF_SERIAL     = 16'h0000;
  localparam int unsigned OPT_SERIAL_BIT = 0;
  localparam int unsigned OPT_PULLDN_BIT = 1;
  localparam int unsigned OPT_WAKE_BIT   = 2;
  localparam int unsigned PWR_SELF_BIT   = 8;
  localparam int unsigned PIN_SEL_W      = 4;
  localparam int unsigned NUM_PINS       = 4;
  localparam int unsigned NUM_INV        = 8;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned WAKE_MS        = 20;
  localparam int unsigned WAKE_CYCLES    = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned STRETCH_CYCLES = 4096;
  typedef enum logic [3:0] {
    NVCFG_DRIVE_EN = 4'h0, NVCFG_RXACT = 4'h1, NVCFG_TXACT = 4'h2, NVCFG_TXRXACT = 4'h3,
    NVCFG_POWER_EN = 4'h4, NVCFG_SLEEP = 4'h5, NVCFG_CHARGE = 4'h6, NVCFG_CHARGE_N = 4'h7,
    NVCFG_LOW = 4'h8, NVCFG_HIGH = 4'h9
  } nvcfg_pinfn_type;
  typedef enum logic [1:0] {
    NVCFG_IDLE = 2'b00, NVCFG_READ = 2'b01, NVCFG_DONE = 2'b11
  } nvcfg_state_type;
endpackage

/* design/nvcfg_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module nvcfg_stretch
  import nvcfg_pkg::*;
#(
  parameter int unsigned CYCLES = STRETCH_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);
  logic [12:0] count_reg;
  // Each byte reloads the counter, so a busy stream keeps the indicator lit.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= 13'h0000;
    end else if (trigger) begin
      count_reg <= 13'(CYCLES);
    end else if (count_reg != 13'h0000) begin
      count_reg <= count_reg - 13'h0001;
    end
  end
  assign active = (count_reg != 13'h0000);
  a_stretch_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trigger |=> active [*8]) else $error("stretch did not hold after trigger");
endmodule // nvcfg_stretch
`default_nettype wire

/* design/nvcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module nvcfg_top
  import nvcfg_pkg::*;
#(
  parameter int unsigned WAKE_CNT = WAKE_CYCLES,
  parameter int unsigned STRETCH  = STRETCH_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        usb_bus_reset,
  output logic             mem_rd_en,
  output logic [2:0]       mem_addr,
  input  wire logic [15:0] mem_rd_data,
  input  wire logic        mem_rd_valid,
  output logic             cfg_loaded,
  output logic [15:0]      usb_version,
  output logic             self_powered,
  output logic [7:0]       max_power,
  output logic             serial_enable,
  output logic [15:0]      serial_value,
  input  wire logic        suspended,
  input  wire logic        enumerated,
  input  wire logic        charger_detected,
  input  wire logic        tx_byte,
  input  wire logic        rx_byte,
  input  wire logic        tx_frame_lead,
  input  wire logic        tx_stop_done,
  input  wire logic [7:0]  uart_core_out,
  output logic [7:0]       uart_pin_out,
  input  wire logic [7:0]  uart_pin_in,
  output logic [7:0]       uart_core_in,
  output logic             uart_pull_down,
  input  wire logic        ring_in_n,
  output logic             remote_wake,
  output logic [3:0]       config_io_pins_o,
  output logic [3:0]       config_io_pins_oe
);
  logic [15:0] cfg_reg [CFG_WORDS];
  nvcfg_state_type state_reg;
  logic [2:0]  addr_reg;
  logic        ri_s1_reg, ri_s2_reg, ri_s3_reg, ri_low_reg;
  logic [22:0] wake_cnt_reg;
  logic        drive_en_reg, wake_reg, bus_reset_d_reg;
  logic        tx_act, rx_act;
  logic [7:0]  inv;

  // Any bus reset restarts the scan; the words last loaded (defaults after power-on) stand until the memory answers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg       <= NVCFG_IDLE;
      addr_reg        <= 3'h0;
      bus_reset_d_reg <= 1'b0;
    end else begin
      bus_reset_d_reg <= usb_bus_reset;
      if (usb_bus_reset && !bus_reset_d_reg) begin
        state_reg <= NVCFG_IDLE;
        addr_reg  <= 3'h0;
      end else begin
        unique case (state_reg)
          NVCFG_IDLE: state_reg <= NVCFG_READ;
          NVCFG_READ: if (mem_rd_valid) begin
            if (addr_reg == 3'(CFG_WORDS - 1)) state_reg <= NVCFG_DONE;
            addr_reg <= addr_reg + 3'h1;
          end
          NVCFG_DONE: state_reg <= NVCFG_DONE;
          default:    state_reg <= NVCFG_IDLE;
        endcase
      end
    end
  end
  assign mem_rd_en  = (state_reg == NVCFG_READ);
  assign mem_addr   = addr_reg;
  assign cfg_loaded = (state_reg == NVCFG_DONE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CFG_WORDS; i++) cfg_reg[i] <= 16'h0000;
      cfg_reg[ADDR_USBVER]  <= DEF_USBVER;
      cfg_reg[ADDR_POWER]   <= DEF_POWER;
      cfg_reg[ADDR_OPTIONS] <= DEF_OPTIONS;
      cfg_reg[ADDR_PINS]    <= DEF_PINS;
      cfg_reg[ADDR_INVERT]  <= DEF_INVERT;
      cfg_reg[ADDR_SERIAL]  <= DEF_SERIAL;
    end else if (state_reg == NVCFG_READ && mem_rd_valid) begin
      cfg_reg[addr_reg] <= mem_rd_data;
    end
  end

  // Descriptor values are registered so the host side sees stable fields.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      usb_version   <= DEF_USBVER;
      self_powered  <= DEF_POWER[PWR_SELF_BIT];
      max_power     <= DEF_POWER[7:0];
      serial_enable <= DEF_OPTIONS[OPT_SERIAL_BIT];
      serial_value  <= DEF_SERIAL;
    end else begin
      usb_version   <= cfg_reg[ADDR_USBVER];
      self_powered  <= cfg_reg[ADDR_POWER][PWR_SELF_BIT];
      max_power     <= cfg_reg[ADDR_POWER][7:0];
      serial_enable <= cfg_reg[ADDR_OPTIONS][OPT_SERIAL_BIT];
      serial_value  <= cfg_reg[ADDR_SERIAL];
    end
  end

  assign inv = cfg_reg[ADDR_INVERT][7:0];
  assign uart_pin_out   = uart_core_out ^ inv;
  assign uart_core_in   = uart_pin_in ^ inv;
  assign uart_pull_down = suspended & cfg_reg[ADDR_OPTIONS][OPT_PULLDN_BIT];

  nvcfg_stretch #(.CYCLES(STRETCH)) u_tx (
    .sys_clk(sys_clk), .rst_n(rst_n), .trigger(tx_byte), .active(tx_act));
  nvcfg_stretch #(.CYCLES(STRETCH)) u_rx (
    .sys_clk(sys_clk), .rst_n(rst_n), .trigger(rx_byte), .active(rx_act));

  // The lead strobe comes one bit before the start bit from the UART timer.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_en_reg <= 1'b0;
    end else if (tx_frame_lead) begin
      drive_en_reg <= 1'b1;
    end else if (tx_stop_done) begin
      drive_en_reg <= 1'b0;
    end
  end

  // Ring input passes three flops; only agreeing second and third stages count.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ri_s1_reg  <= 1'b1;
      ri_s2_reg  <= 1'b1;
      ri_s3_reg  <= 1'b1;
      ri_low_reg <= 1'b0;
    end else begin
      ri_s1_reg <= ring_in_n ^ inv[7];
      ri_s2_reg <= ri_s1_reg;
      ri_s3_reg <= ri_s2_reg;
      if (ri_s2_reg == ri_s3_reg) ri_low_reg <= ~ri_s3_reg;
    end
  end

  // Wake is signalled once the ring level has been low for the full interval.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt_reg <= 23'h00_0000;
      wake_reg     <= 1'b0;
    end else if (!(suspended && ri_low_reg && cfg_reg[ADDR_OPTIONS][OPT_WAKE_BIT])) begin
      wake_cnt_reg <= 23'h00_0000;
      wake_reg     <= 1'b0;
    end else if (wake_cnt_reg == 23'(WAKE_CNT - 1)) begin
      wake_reg     <= 1'b1;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 23'h00_0001;
    end
  end
  assign remote_wake = wake_reg;

  function automatic logic [1:0] pin_drive(input logic [3:0] sel);
    // Returns {oe, out}; activity functions are open drain, driven only low.
    unique case (sel)
      NVCFG_DRIVE_EN: pin_drive = {1'b1, drive_en_reg};
      NVCFG_RXACT:    pin_drive = {rx_act, 1'b0};
      NVCFG_TXACT:    pin_drive = {tx_act, 1'b0};
      NVCFG_TXRXACT:  pin_drive = {tx_act | rx_act, 1'b0};
      NVCFG_POWER_EN: pin_drive = {1'b1, suspended};
      NVCFG_SLEEP:    pin_drive = {1'b1, ~suspended};
      NVCFG_CHARGE:   pin_drive = {1'b1, charger_detected & suspended & ~enumerated};
      NVCFG_CHARGE_N: pin_drive = {1'b1, ~(charger_detected & suspended & ~enumerated)};
      NVCFG_LOW:      pin_drive = 2'b10;
      NVCFG_HIGH:     pin_drive = 2'b11;
      default:        pin_drive = 2'b00;
    endcase
  endfunction

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      {config_io_pins_oe[p], config_io_pins_o[p]} =
        pin_drive(cfg_reg[ADDR_PINS][p*PIN_SEL_W +: PIN_SEL_W]);
    end
  end

  a_sleep_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_reg[ADDR_PINS][15:12] == NVCFG_SLEEP) |-> (config_io_pins_o[3] == ~suspended))
    else $error("sleep pin level wrong");
  a_charge_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enumerated && cfg_reg[ADDR_PINS][15:12] == NVCFG_CHARGE) |-> !config_io_pins_o[3])
    else $error("charge output active while enumerated");
  a_pulldown_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uart_pull_down |-> suspended)
    else $error("pull-down outside suspend");
  a_invert_path: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (uart_pin_out ^ uart_core_out) == cfg_reg[ADDR_INVERT][7:0])
    else $error("invert mask not applied");
  a_drive_en_lead: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_frame_lead |=> drive_en_reg)
    else $error("transmit enable did not rise");
  a_drive_en_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tx_stop_done && !tx_frame_lead) |=> !drive_en_reg)
    else $error("transmit enable did not fall");
  // The wake checks look one cycle back, since suspend may drop as the flag rises.
  a_wake_needs_ring: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(wake_reg) |-> $past(ri_low_reg) && $past(suspended))
    else $error("wake without ring");
  a_wake_interval: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(wake_reg) |-> ($past(wake_cnt_reg) == 23'(WAKE_CNT - 1)))
    else $error("wake before full interval");
  a_wake_enabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
    remote_wake |-> $past(cfg_reg[ADDR_OPTIONS][OPT_WAKE_BIT]))
    else $error("wake while disabled");
  a_scan_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (usb_bus_reset && !bus_reset_d_reg) |=> ##1 mem_rd_en)
    else $error("no rescan");
  a_scan_advance: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mem_rd_en && mem_rd_valid && !(usb_bus_reset && !bus_reset_d_reg))
    |=> (mem_addr == $past(mem_addr) + 3'h1))
    else $error("scan address did not advance");
  a_version_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_loaded |=> (usb_version == $past(cfg_reg[ADDR_USBVER])))
    else $error("descriptor version not loaded");
  a_act_low_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_reg[ADDR_PINS][7:4] == NVCFG_RXACT) |-> (config_io_pins_oe[1] == rx_act)
    && !config_io_pins_o[1])
    else $error("rx activity pin drive wrong");
  a_tx_low_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_reg[ADDR_PINS][11:8] == NVCFG_TXACT) |-> (config_io_pins_oe[2] == tx_act)
    && !config_io_pins_o[2])
    else $error("tx activity pin drive wrong");
endmodule // nvcfg_top
`default_nettype wire

/* tb/nvcfg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nvcfg_mem_model (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            mem_rd_en,
  input  wire logic [2:0]      mem_addr,
  input  wire logic [3:0]      lat,
  input  wire logic [7:0][15:0] image,
  output logic [15:0]          mem_rd_data,
  output logic                 mem_rd_valid
);
  logic [3:0] wait_reg;
  // Data toggles between words so a sample one cycle late reads the inverted value.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wait_reg     <= 4'h0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 16'h5A5A;
    end else if (mem_rd_en && !mem_rd_valid && wait_reg == lat) begin
      wait_reg     <= 4'h0;
      mem_rd_valid <= 1'b1;
      mem_rd_data  <= image[mem_addr];
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd_en && !mem_rd_valid) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule // nvcfg_mem_model
`default_nettype wire

/* tb/tb_nvcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_nvcfg_top;
  import nvcfg_pkg::*;
  localparam int unsigned STR = 16;
  logic sys_clk = 0, rst_n = 0, usb_bus_reset = 0, suspended = 0, enumerated = 1;
  logic charger_detected = 0, tx_byte = 0, rx_byte = 0, tx_frame_lead = 0, tx_stop_done = 0;
  logic ring_in_n = 1, mem_rd_en, mem_rd_valid, cfg_loaded, self_powered, serial_enable;
  logic uart_pull_down, remote_wake;
  logic [2:0] mem_addr;
  logic [3:0] lat = 0, config_io_pins_o, config_io_pins_oe;
  logic [7:0] uart_core_out = 8'h3C, uart_pin_in = 8'h5A, uart_pin_out, uart_core_in, max_power;
  logic [15:0] mem_rd_data, usb_version, serial_value;
  logic [7:0][15:0] image;
  int bad_count = 0, compares = 0;
  always #2.5 sys_clk = ~sys_clk;
  nvcfg_top #(.WAKE_CNT(50), .STRETCH(STR)) dut_u (.sys_clk, .rst_n, .usb_bus_reset, .mem_rd_en,
    .mem_addr, .mem_rd_data, .mem_rd_valid, .cfg_loaded, .usb_version, .self_powered, .max_power,
    .serial_enable, .serial_value, .suspended, .enumerated, .charger_detected, .tx_byte, .rx_byte,
    .tx_frame_lead, .tx_stop_done, .uart_core_out, .uart_pin_out, .uart_pin_in, .uart_core_in,
    .uart_pull_down, .ring_in_n, .remote_wake, .config_io_pins_o, .config_io_pins_oe);
  nvcfg_mem_model mem_u (.sys_clk, .rst_n, .mem_rd_en, .mem_addr, .lat, .image, .mem_rd_data,
    .mem_rd_valid);
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_loaded;
    int i;
    for (i = 0; i < 200; i++) begin
      if (cfg_loaded === 1'b1 && mem_rd_en === 1'b0) break;
      step(1);
    end
    if (i == 200) begin
      bad_count++;
      report_and_stop();
    end
    step(2);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  initial begin
    image = {16'h0, 16'h0, 16'h4D2B, DEF_INVERT, 16'h5210, DEF_OPTIONS, DEF_POWER, DEF_USBVER};
    step(1);
    chk("reset pin oe", 16'h0009, config_io_pins_oe);
    chk("reset sleep pin", 16'h0001, config_io_pins_o[3]);
    step(19);
    rst_n = 1'b1;
    wait_loaded();
    chk("usb version", 16'h0200, usb_version);
    chk("self powered", 16'h0000, self_powered);
    chk("max power", 16'h002D, max_power);
    chk("serial enable", 16'h0001, serial_enable);
    chk("serial value", 16'h4D2B, serial_value);
    $display("test descriptors done");
    pulse(rx_byte);
    chk("rx pin driven", 16'h0001, config_io_pins_oe[2:1]);
    chk("rx pin low", 16'h0000, config_io_pins_o[1]);
    step(8);
    pulse(rx_byte);
    step(STR - 2);
    chk("rx retrigger", 16'h0001, config_io_pins_oe[1]);
    step(4);
    chk("rx released", 16'h0000, config_io_pins_oe[1]);
    pulse(tx_byte);
    chk("tx pin driven", 16'h0002, config_io_pins_oe[2:1]);
    step(STR + 2);
    chk("tx released", 16'h0000, config_io_pins_oe[2]);
    pulse(tx_frame_lead);
    chk("drive enable on", 16'h0001, config_io_pins_o[0]);
    step(3);
    pulse(tx_stop_done);
    chk("drive enable off", 16'h0000, config_io_pins_o[0]);
    $display("test activity done");
    suspended = 1'b1;
    step(1);
    chk("sleep pin", 16'h0000, config_io_pins_o[3]);
    chk("pull down off", 16'h0000, uart_pull_down);
    chk("pin out plain", uart_core_out, uart_pin_out);
    chk("core in plain", uart_pin_in, uart_core_in);
    ring_in_n = 1'b0;
    step(30);
    chk("wake early", 16'h0000, remote_wake);
    for (int k = 0; k < 40 && remote_wake !== 1'b1; k++) step(1);
    chk("wake raised", 16'h0001, remote_wake);
    if (remote_wake !== 1'b1) report_and_stop();
    ring_in_n = 1'b1;
    step(6);
    chk("wake dropped", 16'h0000, remote_wake);
    suspended = 1'b0;
    $display("test suspend done");
    // A slower memory on the rescan checks that the scan waits for each word.
    lat = 4'h3;
    image = {16'h0, 16'h0, 16'h4D2B, 16'h00A5, 16'h6333, 16'h0007, DEF_POWER, DEF_USBVER};
    usb_bus_reset = 1'b1;
    step(1);
    usb_bus_reset = 1'b0;
    step(3);
    wait_loaded();
    pulse(tx_byte);
    chk("combined on tx", 16'h0007, config_io_pins_oe[2:0]);
    step(STR + 2);
    pulse(rx_byte);
    chk("combined on rx", 16'h0000, config_io_pins_o[2:0]);
    chk("combined rx drive", 16'h0007, config_io_pins_oe[2:0]);
    charger_detected = 1'b1;
    suspended = 1'b1;
    step(1);
    chk("charger enumerated", 16'h0000, config_io_pins_o[3]);
    chk("pull down on", 16'h0001, uart_pull_down);
    chk("pin out inverted", uart_core_out ^ 8'hA5, uart_pin_out);
    chk("core in inverted", uart_pin_in ^ 8'hA5, uart_core_in);
    enumerated = 1'b0;
    step(1);
    chk("charger dedicated", 16'h0001, config_io_pins_o[3]);
    $display("test rescan done");
    // Third scan: new descriptor words and the pin functions no other test selects.
    image = {16'h0, 16'h0, 16'h1234, 16'h0000, 16'h7984, 16'h0000, 16'h0132, 16'h0110};
    usb_bus_reset = 1'b1;
    step(1);
    usb_bus_reset = 1'b0;
    step(3);
    wait_loaded();
    chk("loaded version", 16'h0110, usb_version);
    chk("loaded self power", 16'h0001, self_powered);
    chk("loaded max power", 16'h0032, max_power);
    chk("serial disabled", 16'h0000, serial_enable);
    chk("serial reloaded", 16'h1234, serial_value);
    chk("spare pin drive", 16'h000F, config_io_pins_oe);
    chk("spare pin level", 16'h0005, config_io_pins_o);
    chk("pull down cleared", 16'h0000, uart_pull_down);
    ring_in_n = 1'b0;
    step(60);
    chk("wake disabled", 16'h0000, remote_wake);
    ring_in_n = 1'b1;
    $display("test spare pins done");
    report_and_stop();
  end
endmodule // tb_nvcfg_top
`default_nettype wire
